// ### src/gpio_pkg.sv
/*
  Package for the four pin general purpose port: register offsets, field
  widths, reset values and the output source selector encoding.
  Assumes an 8-bit register port with offsets given as plain indices.
*/
package gpio_pkg;
  localparam int          NUM_PINS     = 4;
  localparam int          NUM_OUT_PINS = 3;
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 8;
  localparam int          SYNC_STAGES  = 2;

  localparam logic [3:0] OFF_PORT_PIN_LEVELS   = 4'h0;
  localparam logic [3:0] OFF_DIRECTION_CONTROL = 4'h1;
  localparam logic [3:0] OFF_OUTPUT_LATCH      = 4'h2;
  localparam logic [3:0] OFF_ANALOG_SELECT     = 4'h3;
  localparam logic [3:0] OFF_PULLUP_ENABLE     = 4'h4;
  localparam logic [3:0] OFF_OPTION_CONFIG     = 4'h5;
  localparam logic [3:0] OFF_PERIPH_ENABLE     = 4'h6;

  localparam logic [2:0] RST_DIRECTION     = 3'h7;
  localparam logic [2:0] RST_OUTPUT_LATCH  = 3'h0;
  localparam logic [2:0] RST_ANALOG_SELECT = 3'h7;
  localparam logic [3:0] RST_PULLUP_ENABLE = 4'hF;
  localparam logic       RST_GLOBAL_PU_DIS = 1'b1;
  localparam logic [7:0] RST_PERIPH_ENABLE = 8'h00;

  localparam int          GLOBAL_PU_DIS_BIT = 7;
  localparam int          DIR_BIT3_ONE      = 3;
  localparam int          PERIPH_W          = 8;

  // peripheral enable bit positions in the periph enable register
  localparam int          PE_SERIAL_DATA = 0;
  localparam int          PE_WAVE_A      = 1;
  localparam int          PE_PULSE_ONE   = 2;
  localparam int          PE_WAVE_B      = 3;
  localparam int          PE_PULSE_TWO   = 4;
  localparam int          PE_LOGIC_CELL  = 5;
  localparam int          PE_NUMERIC_OSC = 6;
  localparam int          PE_CLOCK_REF   = 7;
endpackage : gpio_pkg

// ### src/pin_sync_if.sv
/*
  Interface carrying raw pin levels into the synchroniser and the
  synchronised levels back out to the port core.
  Assumes a single clock domain on the consumer side.
*/
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface : pin_sync_if

// ### src/pin_sync.sv
/*
  Two stage synchroniser for the port pin levels.
  Assumes pin inputs may change at any time relative to clk.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // pin levels
  pin_sync_if.dst   sif
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  always_comb begin
    nxt_state        = state_ff;
    nxt_state.meta   = sif.raw;
    nxt_state.stable = state_ff.meta;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sif.synced = state_ff.stable;
endmodule : pin_sync

// ### src/gpio_port.sv
/*
  Four pin general purpose port: direction, output latch, pin level read,
  analog select masking, weak pull-up control and a fixed priority output
  multiplexer for on-chip peripherals.
  Assumes a register port whose strobes are one cycle wide and never both
  high; pin inputs may be asynchronous and are synchronised here.
*/
// Our own choices: the placing of the registers and the strobed register port.
// Functional notes
// - a write to the pin register updates the output latch like a latch write.
// - latch register reads stored values; pin register reads sampled pin levels.
// - direction bit 1 disables the driver; 0 drives the selected output value.
// - pin register writes are read-modify-write into the output latch; here all three latch bits take the write data directly.
// - direction bits still control drivers on analog pins.
// - analog pins read as zero through the pin register.
// - per pin pull-up enable; pull-up off whenever a pin is an output.
// - the global pull-up disable bit is set at reset, so all pull-ups start off.
// - analog select disables the pin's digital input buffer.
// - analog select never affects digital output drive.
// - analog select bits reset to analog; software clears them for digital use.
// - with several sources enabled, the highest priority source owns the pin.
// - fixed per pin source priority table, pin3 has no output.
// - peripheral outputs may drive pins that are in analog mode.
// - an enabled peripheral displaces the latch, the pin stays readable.
// - pin register bits 7-4 read zero; pin3 is read-only.
// - pull-up active only with its enable set and global disable clear.
`timescale 1ns/1ps
module gpio_port
  import gpio_pkg::*;
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // register port
  input  wire logic [gpio_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [gpio_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [gpio_pkg::DATA_W-1:0]   reg_rdata,
  // peripheral output values
  input  wire logic                          serial_program_data,
  input  wire logic                          waveform_generator_a,
  input  wire logic                          pulse_modulator_one,
  input  wire logic                          waveform_generator_b,
  input  wire logic                          pulse_modulator_two,
  input  wire logic                          logic_cell,
  input  wire logic                          numeric_oscillator,
  input  wire logic                          clock_reference_out,
  // pins
  input  wire logic [gpio_pkg::NUM_PINS-1:0] pin_in,
  output logic      [gpio_pkg::NUM_OUT_PINS-1:0] pin_out,
  output logic      [gpio_pkg::NUM_OUT_PINS-1:0] pin_oe,
  output logic      [gpio_pkg::NUM_PINS-1:0] pin_pullup_en,
  output logic      [gpio_pkg::NUM_OUT_PINS-1:0] pin_dig_in_en
);
  import gpio_pkg::*;

  typedef struct packed {
    logic [NUM_OUT_PINS-1:0] direction_control;
    logic [NUM_OUT_PINS-1:0] output_latch;
    logic [NUM_OUT_PINS-1:0] analog_select;
    logic [NUM_PINS-1:0]     pullup_enable;
    logic                    global_pullup_disable;
    logic [PERIPH_W-1:0]     periph_enable;
    logic [DATA_W-1:0]       rdata;
    logic [NUM_OUT_PINS-1:0] out;
    logic [NUM_OUT_PINS-1:0] oe;
    logic [NUM_PINS-1:0]     pu;
    logic [NUM_OUT_PINS-1:0] din_en;
  } port_state_t;

  port_state_t state_ff;
  port_state_t nxt_state;

  logic [NUM_PINS-1:0]     pin_levels;
  logic [NUM_PINS-1:0]     pin_view;
  logic [NUM_OUT_PINS-1:0] src_val;
  logic [NUM_OUT_PINS-1:0] periph_owns;
  logic [NUM_OUT_PINS-1:0] periph_val;
  logic [NUM_PINS-1:0]     is_output;

  pin_sync_if #(.W(NUM_PINS)) sif ();

  assign sif.raw = pin_in;

  // two flops keep metastability away from software reads
  pin_sync #(.W(NUM_PINS)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .sif   (sif)
  );

  assign pin_levels = sif.synced;

  // analog pins read zero; pin3 has no analog select and is always digital
  always_comb begin
    pin_view    = pin_levels & {1'b1, ~state_ff.analog_select};
    pin_view[3] = pin_levels[3];
  end

  // fixed priority output multiplexer, analog select plays no part here
  always_comb begin
    periph_owns = '0;
    periph_val  = '0;
    // pin0
    if (state_ff.periph_enable[PE_SERIAL_DATA]) begin
      periph_owns[0] = 1'b1;
      periph_val[0]  = serial_program_data;
    end else if (state_ff.periph_enable[PE_WAVE_A]) begin
      periph_owns[0] = 1'b1;
      periph_val[0]  = waveform_generator_a;
    end else if (state_ff.periph_enable[PE_PULSE_ONE]) begin
      periph_owns[0] = 1'b1;
      periph_val[0]  = pulse_modulator_one;
    end
    // pin1
    if (state_ff.periph_enable[PE_WAVE_B]) begin
      periph_owns[1] = 1'b1;
      periph_val[1]  = waveform_generator_b;
    end else if (state_ff.periph_enable[PE_PULSE_TWO]) begin
      periph_owns[1] = 1'b1;
      periph_val[1]  = pulse_modulator_two;
    end else if (state_ff.periph_enable[PE_LOGIC_CELL]) begin
      periph_owns[1] = 1'b1;
      periph_val[1]  = logic_cell;
    end
    // pin2
    if (state_ff.periph_enable[PE_NUMERIC_OSC]) begin
      periph_owns[2] = 1'b1;
      periph_val[2]  = numeric_oscillator;
    end else if (state_ff.periph_enable[PE_CLOCK_REF]) begin
      periph_owns[2] = 1'b1;
      periph_val[2]  = clock_reference_out;
    end
    // the latch only reaches a pin that no peripheral has claimed
    src_val = (periph_val & periph_owns) | (state_ff.output_latch & ~periph_owns);
  end

  // pin3 never drives, so it never counts as an output
  assign is_output = {1'b0, ~state_ff.direction_control};

  always_comb begin
    nxt_state = state_ff;

    // register writes
    if (reg_wr) begin
      if (reg_addr == OFF_PORT_PIN_LEVELS) begin
        // all three latch bits take the written data, no pin value is read back
        nxt_state.output_latch = reg_wdata[NUM_OUT_PINS-1:0];
      end else if (reg_addr == OFF_OUTPUT_LATCH) begin
        nxt_state.output_latch = reg_wdata[NUM_OUT_PINS-1:0];
      end else if (reg_addr == OFF_DIRECTION_CONTROL) begin
        nxt_state.direction_control = reg_wdata[NUM_OUT_PINS-1:0];
      end else if (reg_addr == OFF_ANALOG_SELECT) begin
        nxt_state.analog_select = reg_wdata[NUM_OUT_PINS-1:0];
      end else if (reg_addr == OFF_PULLUP_ENABLE) begin
        nxt_state.pullup_enable = reg_wdata[NUM_PINS-1:0];
      end else if (reg_addr == OFF_OPTION_CONFIG) begin
        nxt_state.global_pullup_disable = reg_wdata[GLOBAL_PU_DIS_BIT];
      end else if (reg_addr == OFF_PERIPH_ENABLE) begin
        nxt_state.periph_enable = reg_wdata;
      end
    end

    // register reads, data valid the cycle after the strobe only
    nxt_state.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == OFF_PORT_PIN_LEVELS) begin
        nxt_state.rdata = {4'h0, pin_view};
      end else if (reg_addr == OFF_OUTPUT_LATCH) begin
        nxt_state.rdata = {5'h00, state_ff.output_latch};
      end else if (reg_addr == OFF_DIRECTION_CONTROL) begin
        nxt_state.rdata = {5'h01, state_ff.direction_control};
      end else if (reg_addr == OFF_ANALOG_SELECT) begin
        nxt_state.rdata = {5'h00, state_ff.analog_select};
      end else if (reg_addr == OFF_PULLUP_ENABLE) begin
        nxt_state.rdata = {4'h0, state_ff.pullup_enable};
      end else if (reg_addr == OFF_OPTION_CONFIG) begin
        nxt_state.rdata = {state_ff.global_pullup_disable, 7'h00};
      end else if (reg_addr == OFF_PERIPH_ENABLE) begin
        nxt_state.rdata = state_ff.periph_enable;
      end
    end

    // pin drive: direction alone gates the driver, analog mode does not
    nxt_state.out = src_val;
    nxt_state.oe  = ~state_ff.direction_control;

    // pull-ups
    nxt_state.pu = state_ff.pullup_enable & ~is_output
                   & {NUM_PINS{~state_ff.global_pullup_disable}};

    // digital input buffer enable
    nxt_state.din_en = ~state_ff.analog_select;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff                       <= '0;
      state_ff.direction_control     <= RST_DIRECTION;
      state_ff.output_latch          <= RST_OUTPUT_LATCH;
      state_ff.analog_select         <= RST_ANALOG_SELECT;
      state_ff.pullup_enable         <= RST_PULLUP_ENABLE;
      state_ff.global_pullup_disable <= RST_GLOBAL_PU_DIS;
      state_ff.periph_enable         <= RST_PERIPH_ENABLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata     = state_ff.rdata;
  assign pin_out       = state_ff.out;
  assign pin_oe        = state_ff.oe;
  assign pin_pullup_en = state_ff.pu;
  assign pin_dig_in_en = state_ff.din_en;
endmodule : gpio_port

// ### verif/gpio_port_props.sv
/* port-level properties of the four pin port.
   assumes binding to gpio_port on its single clock. */
`timescale 1ns/1ps
module gpio_port_props (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] pin_oe,
  input wire logic [3:0] pin_pullup_en,
  input wire logic [2:0] pin_dig_in_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_oe_dir; reg_wr && reg_addr == 4'h1 |=> ##1 pin_oe == ~$past(reg_wdata[2:0], 2);
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("driver enable wrong");
  property p_din; reg_wr && reg_addr == 4'h3 |=> ##1 pin_dig_in_en == ~$past(reg_wdata[2:0], 2);
  endproperty
  a_din: assert property (p_din) else $error("input buffer enable wrong");
  property p_ana_rd; reg_rd && reg_addr == 4'h0 |=>
    reg_rdata[7:4] == 4'h0 && (reg_rdata[2:0] & ~pin_dig_in_en) == 3'h0; endproperty
  a_ana_rd: assert property (p_ana_rd) else $error("pin read not masked");
  property p_pu_out; (pin_pullup_en[2:0] & pin_oe) == 3'h0; endproperty
  a_pu_out: assert property (p_pu_out) else $error("pull-up on output pin");
  property p_rst_pu; !$past(rst_b) |-> pin_pullup_en == 4'h0 && pin_oe == 3'h0; endproperty
  a_rst_pu: assert property (p_rst_pu) else $error("pins not quiet after reset");
  property p_gdis; reg_wr && reg_addr == 4'h5 && reg_wdata[7] |=> ##1 pin_pullup_en == 4'h0;
  endproperty
  a_gdis: assert property (p_gdis) else $error("pull-up despite global off");
  property p_lat; reg_wr && (reg_addr == 4'h0 || reg_addr == 4'h2) ##1 !reg_wr ##1
    reg_rd && reg_addr == 4'h2 |=> reg_rdata == {5'h00, $past(reg_wdata[2:0], 3)}; endproperty
  a_lat: assert property (p_lat) else $error("latch read wrong");
endmodule : gpio_port_props

// ### verif/pin_board.sv
/* board model of the four pins.
   assumes port outputs and external drive never fight. */
`timescale 1ns/1ps
module pin_board (
  input  wire logic       clk,
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  input  wire logic [3:0] pin_pullup_en,
  input  wire logic [3:0] ext_val,
  input  wire logic [3:0] ext_en,
  output logic      [3:0] pin_in
);
  logic       flt_ff = 1'b0;
  logic [3:0] oe4;
  logic [3:0] out4;
  assign oe4 = {1'b0, pin_oe};
  assign out4 = {1'b0, pin_out};
  // an undriven pin without its pull-up has no defined level, so it wanders every cycle
  always @(posedge clk) flt_ff <= ~flt_ff;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = oe4[i] ? out4[i] : ext_en[i] ? ext_val[i] :
                  pin_pullup_en[i] ? 1'b1 : flt_ff;
    end
  end
endmodule : pin_board

// ### verif/tb.sv
/* self-checking bench of the four pin port.
   assumes gpio_pkg indices and one-cycle read latency. */
`timescale 1ns/1ps
module tb;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] src = 8'h00;
  logic [3:0] ext_val = 4'h0;
  logic [3:0] ext_en = 4'h0;
  logic [3:0] pin_in;
  logic [2:0] pin_out;
  logic [2:0] pin_oe;
  logic [3:0] pin_pullup_en;
  logic [2:0] pin_dig_in_en;
  int         errors = 0;
  int         compares = 0;
  always #2.5 clk = ~clk;
  gpio_port dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_program_data(src[0]),
    .waveform_generator_a(src[1]), .pulse_modulator_one(src[2]), .waveform_generator_b(src[3]),
    .pulse_modulator_two(src[4]), .logic_cell(src[5]), .numeric_oscillator(src[6]),
    .clock_reference_out(src[7]), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .pin_dig_in_en(pin_dig_in_en));
  pin_board board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask : rchk
  // pins trail register state by one extra cycle
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic t_reset;
    chk("oe", {5'h00, pin_oe}, 8'h00);
    chk("out", {5'h00, pin_out}, 8'h00);
    chk("pu", {4'h0, pin_pullup_en}, 8'h00);
    chk("din", {5'h00, pin_dig_in_en}, 8'h00);
    rchk("dir", 4'h1, 8'h0F);
    rchk("ana", 4'h3, 8'h07);
    rchk("wpu", 4'h4, 8'h0F);
    rchk("opt", 4'h5, 8'h80);
    rchk("gap", 4'hA, 8'h00);
  endtask : t_reset
  task automatic t_latch;
    wr(4'h3, 8'h00);
    wr(4'h0, 8'hFD);
    rchk("lat", 4'h2, 8'h05);
    wr(4'h1, 8'h00);
    ext_val <= 4'h8;
    ext_en <= 4'h8;
    settle;
    chk("oe", {5'h00, pin_oe}, 8'h07);
    chk("out", {5'h00, pin_out}, 8'h05);
    chk("din", {5'h00, pin_dig_in_en}, 8'h07);
    rchk("pins", 4'h0, 8'h0D);
    wr(4'h1, 8'h01);
    ext_en <= 4'h9;
    settle;
    rchk("pins", 4'h0, 8'h0C);
    rchk("lat", 4'h2, 8'h05);
  endtask : t_latch
  task automatic t_analog;
    wr(4'h3, 8'h07);
    settle;
    chk("din", {5'h00, pin_dig_in_en}, 8'h00);
    chk("oe", {5'h00, pin_oe}, 8'h06);
    chk("out", {5'h00, pin_out}, 8'h05);
    rchk("pins", 4'h0, 8'h08);
  endtask : t_analog
  task automatic t_prio;
    int p;
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h07);
    for (int k = 0; k < 8; k++) begin
      p = (k < 3) ? 0 : (k < 6) ? 1 : 2;
      wr(4'h6, 8'hFF << k);
      src <= ~(8'h01 << k);
      settle;
      chk("prio", {7'h00, pin_out[p]}, 8'h00);
      src <= 8'h01 << k;
      settle;
      chk("prio", {7'h00, pin_out[p]}, 8'h01);
    end
    rchk("pe", 4'h6, 8'h80);
    wr(4'h6, 8'h00);
    settle;
    chk("out", {5'h00, pin_out}, 8'h07);
  endtask : t_prio
  task automatic t_pullup;
    wr(4'h1, 8'h07);
    wr(4'h5, 8'h00);
    settle;
    chk("pu", {4'h0, pin_pullup_en}, 8'h0F);
    wr(4'h1, 8'h06);
    settle;
    chk("pu", {4'h0, pin_pullup_en}, 8'h0E);
    wr(4'h5, 8'h80);
    settle;
    chk("pu", {4'h0, pin_pullup_en}, 8'h00);
  endtask : t_pullup
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    settle;
    t_reset;
    t_latch;
    t_analog;
    t_prio;
    t_pullup;
    report_and_stop;
  end
endmodule : tb
bind gpio_port gpio_port_props props (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .pin_dig_in_en(pin_dig_in_en));
